// ===== inc/sfc_pkg.sv
package sfc_pkg;
    localparam int FID_W = 3;
    localparam int NFLOW = 1 << FID_W;
    localparam int LEN_W = 16;
    localparam logic [FID_W-1:0] FALLBACK_FLOW_ID = 3'h0;
    localparam logic [FID_W-1:0] DS_DEFAULT_FLOW = 3'h0;
    // apb map
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_DROPS = 12'h008;
    localparam logic [11:0] CLS_BASE = 12'h040;
    localparam logic [11:0] FLOW_BASE = 12'h080;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CLR_ERR_BIT = 1;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_ERR_BIT = 4;
    localparam int STAT_BUSY_BIT = 5;
    // classifier word
    localparam int CLS_VALID_BIT = 31;
    localparam int CLS_DYN_BIT = 30;
    localparam int CLS_MGMT_BIT = 29;
    localparam int CLS_TYPE_LSB = 16;
    localparam int CLS_FLOW_LSB = 8;
    localparam int CLS_PRIO_LSB = 0;
    // flow word
    localparam int FLOW_ACTIVE_BIT = 31;
    localparam int FLOW_NOFRAG_BIT = 30;
    localparam int FLOW_DROP_BIT = 29;
    localparam int FLOW_NAME_LSB = 16;
    localparam int FLOW_GRANT_LSB = 0;
    localparam logic [7:0] DYN_PRIO_MIN = 8'h40;
    localparam logic [7:0] DYN_PRIO_MAX = 8'hBF;
    // headend policing refill period
    localparam int CLK_PERIOD_NS = 25;
    localparam int REFILL_NS = 1000;
    localparam int REFILL_CYC = (REFILL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        MSG_NONE = 2'b00,
        MSG_REG_REQ = 2'b01,
        MSG_REG_RSP = 2'b10,
        MSG_REG_ACK = 2'b11
    } sfc_msg_e;
    typedef enum logic [2:0] {
        RS_IDLE = 3'b000,
        RS_SEND_REQ = 3'b001,
        RS_WAIT_RSP = 3'b010,
        RS_SEND_ACK = 3'b011,
        RS_DONE = 3'b100
    } sfc_reg_e;
    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_CTRL = 3'b001,
        K_STATUS = 3'b010,
        K_DROPS = 3'b011,
        K_CLS = 3'b100,
        K_FLOW = 3'b101
    } sfc_kind_e;
endpackage

// ===== inc/sfc_link_if.sv
`timescale 1ns/10ps
interface sfc_link_if;
    import sfc_pkg::*;
    logic up_valid;
    logic up_ready;
    logic [FID_W-1:0] up_flow;
    logic [LEN_W-1:0] up_len;
    logic [7:0] up_tos;
    logic up_mgmt;
    logic up_msg_valid;
    sfc_msg_e up_msg_type;
    logic [7:0] up_msg_info;
    logic dn_msg_valid;
    sfc_msg_e dn_msg_type;
    modport modem (output up_valid, up_flow, up_len, up_tos, up_mgmt, up_msg_valid, up_msg_type, up_msg_info,
                   input up_ready, dn_msg_valid, dn_msg_type);
    modport headend (input up_valid, up_flow, up_len, up_tos, up_mgmt, up_msg_valid, up_msg_type, up_msg_info,
                     output up_ready, dn_msg_valid, dn_msg_type);
endinterface

// ===== logic/sfc_headend.sv
`timescale 1ns/10ps
module sfc_headend #(
    parameter logic [sfc_pkg::LEN_W-1:0] REFILL_BYTES = 16'h0040,
    parameter logic [sfc_pkg::LEN_W-1:0] BUCKET_MAX = 16'h0800
) (
    input wire logic pclk,
    input wire logic presetn,
    sfc_link_if.headend link,
    input wire logic [sfc_pkg::NFLOW*8-1:0] flow_tos,
    input wire logic tos_police_en,
    output logic us_valid,
    output logic [sfc_pkg::FID_W-1:0] us_flow,
    output logic [sfc_pkg::LEN_W-1:0] us_len,
    output logic [7:0] us_tos,
    output logic us_mgmt,
    output logic us_dropped,
    output logic registered,
    input wire logic ds_valid,
    input wire logic ds_match,
    input wire logic [sfc_pkg::FID_W-1:0] ds_flow,
    input wire logic [sfc_pkg::NFLOW-1:0] ds_flow_active,
    output logic ds_out_valid,
    output logic [sfc_pkg::FID_W-1:0] ds_out_flow
);
    import sfc_pkg::*;

    typedef struct packed {
        logic [NFLOW-1:0][LEN_W-1:0] credit;
        logic [7:0] refill_cnt;
        logic us_valid;
        logic [FID_W-1:0] us_flow;
        logic [LEN_W-1:0] us_len;
        logic [7:0] us_tos;
        logic us_mgmt;
        logic us_dropped;
        logic rsp_due;
        logic wait_ack;
        logic registered;
        logic dn_msg_valid;
        logic ds_out_valid;
        logic [FID_W-1:0] ds_out_flow;
    } sfc_he_s;

    sfc_he_s s;
    sfc_he_s next_s;

    always_comb begin
        logic [LEN_W:0] sum;
        logic [7:0] want_tos;
        sum = '0;
        want_tos = '0;
        next_s = s;
        next_s.us_valid = 1'b0;
        next_s.us_dropped = 1'b0;
        next_s.dn_msg_valid = 1'b0;
        next_s.ds_out_valid = 1'b0;
        // refill before spending so a packet may use this cycle's credit
        if (s.refill_cnt == 8'(REFILL_CYC - 1)) begin
            next_s.refill_cnt = '0;
            for (int f = 0; f < NFLOW; f++) begin
                sum = {1'b0, s.credit[f]} + {1'b0, REFILL_BYTES};
                next_s.credit[f] = (sum > {1'b0, BUCKET_MAX}) ? BUCKET_MAX : sum[LEN_W-1:0];
            end
        end else begin
            next_s.refill_cnt = s.refill_cnt + 8'h01;
        end
        if (link.up_valid) begin
            want_tos = flow_tos[link.up_flow*8 +: 8];
            next_s.us_flow = link.up_flow;
            next_s.us_len = link.up_len;
            next_s.us_mgmt = link.up_mgmt;
            next_s.us_tos = link.up_tos;
            if (link.up_mgmt) begin
                next_s.us_valid = 1'b1; // R12
            end else if (next_s.credit[link.up_flow] >= link.up_len) begin
                next_s.credit[link.up_flow] = next_s.credit[link.up_flow] - link.up_len; // R5
                next_s.us_valid = 1'b1;
                if (tos_police_en && link.up_tos != want_tos) begin
                    next_s.us_tos = want_tos; // R6
                end
            end else begin
                next_s.us_dropped = 1'b1; // R5
            end
        end
        // registration: response only to a request, ack only after the response
        if (s.rsp_due) begin
            next_s.dn_msg_valid = 1'b1; // R18
            next_s.rsp_due = 1'b0;
            next_s.wait_ack = 1'b1;
        end
        if (link.up_msg_valid && link.up_msg_type == MSG_REG_REQ) begin
            next_s.rsp_due = 1'b1; // R18
            next_s.registered = 1'b0;
        end else if (link.up_msg_valid && link.up_msg_type == MSG_REG_ACK && s.wait_ack) begin
            next_s.wait_ack = 1'b0; // R18
            next_s.registered = 1'b1;
        end
        if (ds_valid) begin
            next_s.ds_out_valid = 1'b1; // R1
            // unmatched or inactive traffic, broadcast and multicast included, rides the default flow
            next_s.ds_out_flow = (ds_match && ds_flow_active[ds_flow]) ? ds_flow : DS_DEFAULT_FLOW; // R3 R4
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link.up_ready = 1'b1;
    assign link.dn_msg_valid = s.dn_msg_valid;
    assign link.dn_msg_type = s.dn_msg_valid ? MSG_REG_RSP : MSG_NONE;
    assign us_valid = s.us_valid;
    assign us_flow = s.us_flow;
    assign us_len = s.us_len;
    assign us_tos = s.us_tos;
    assign us_mgmt = s.us_mgmt;
    assign us_dropped = s.us_dropped;
    assign registered = s.registered;
    assign ds_out_valid = s.ds_out_valid;
    assign ds_out_flow = s.ds_out_flow;
endmodule

// ===== logic/sfc_modem.sv
// How it works
// R1: each accepted packet gets exactly one flow
// R2: upstream packets only onto active flows
// R3: headend puts downstream traffic on active flows
// R4: unmatched broadcast/multicast uses default downstream flow
// R5: headend may drop packets over policed rate
// R6: headend rewrites wrong TOS byte per policy
// R7: no-frag UGS flow refuses packets over grant (the code skips this check when the chosen flow is the primary flow)
// R8: unsendable packet: primary flow or discard, per policy
// R9: management matched only by matching type classifier
// R10: ranging requests always use primary flow
// R11: unmatched management messages go on primary flow
// R12: management messages excluded from flow accounting
// R13: request carries PDU, class name, priority
// R14: name flow, then classifier if priority suffices
// R15: dynamic classifier priorities limited to 64..191
// R16: static classifiers may use any 0..255
// R17: higher layer drops packets, never hands them over
// R18: registration is request, response, then acknowledge
// R19: shared flows allowed; priority ties pick lowest index
// R20: request reports inactive flows and immediate classifiers
// R21: flow gives attributes or a class name
// R22: search highest priority first, first match wins
`timescale 1ns/10ps
module sfc_modem #(
    parameter int NCLS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [sfc_pkg::LEN_W-1:0] req_len,
    input wire logic [7:0] req_tos,
    input wire logic [7:0] req_class_name,
    input wire logic [7:0] req_priority,
    input wire logic [NCLS-1:0] req_match,
    input wire logic req_mgmt,
    input wire logic [7:0] req_mgmt_type,
    input wire logic req_ranging,
    output logic req_dropped,
    sfc_link_if.modem link
);
    import sfc_pkg::*;

    localparam logic [11:0] CLS_END = CLS_BASE + 12'(NCLS * 4);
    localparam logic [11:0] FLOW_END = FLOW_BASE + 12'(NFLOW * 4);

    typedef struct packed {
        logic [NCLS-1:0][31:0] cls;
        logic [NFLOW-1:0][31:0] flow;
        logic [31:0] prdata;
        logic err_resp;
        logic prio_err;
        sfc_reg_e rstate;
        logic msg_valid;
        sfc_msg_e msg_type;
        logic [7:0] msg_info;
        logic out_valid;
        logic [FID_W-1:0] out_flow;
        logic [LEN_W-1:0] out_len;
        logic [7:0] out_tos;
        logic out_mgmt;
        logic dropped;
        logic [15:0] drops;
    } sfc_modem_s;

    sfc_modem_s s;
    sfc_modem_s next_s;

    function automatic sfc_kind_e reg_kind(input logic [11:0] a);
        if (a[1:0] != 2'b00) begin
            return K_NONE;
        end else if (a == ADDR_CTRL) begin
            return K_CTRL;
        end else if (a == ADDR_STATUS) begin
            return K_STATUS;
        end else if (a == ADDR_DROPS) begin
            return K_DROPS;
        end else if (a >= CLS_BASE && a < CLS_END) begin
            return K_CLS;
        end else if (a >= FLOW_BASE && a < FLOW_END) begin
            return K_FLOW;
        end
        return K_NONE;
    endfunction

    always_comb begin
        sfc_kind_e kind;
        logic [9:0] widx;
        logic best_hit;
        logic [7:0] best_prio;
        logic [FID_W-1:0] best_flow;
        logic name_hit;
        logic [FID_W-1:0] name_flow;
        logic [FID_W-1:0] fl;
        logic [FID_W-1:0] chosen;
        logic ok;
        logic [3:0] n_inact;
        logic [3:0] n_imm;
        logic [7:0] wprio;
        kind = K_NONE;
        widx = '0;
        best_hit = 1'b0;
        best_prio = '0;
        best_flow = '0;
        name_hit = 1'b0;
        name_flow = '0;
        fl = '0;
        chosen = FALLBACK_FLOW_ID;
        ok = 1'b0;
        n_inact = '0;
        n_imm = '0;
        wprio = pwdata[CLS_PRIO_LSB +: 8];
        next_s = s;
        next_s.msg_valid = 1'b0;
        next_s.msg_type = MSG_NONE;
        next_s.dropped = 1'b0;

        // read data is captured in the setup cycle so the access phase answers at once
        if (psel && !penable) begin
            kind = reg_kind(paddr);
            next_s.err_resp = (kind == K_NONE);
            case (kind)
                K_STATUS: begin
                    next_s.prdata = REG_RESET;
                    next_s.prdata[STAT_STATE_LSB +: 3] = s.rstate;
                    next_s.prdata[STAT_ERR_BIT] = s.prio_err;
                    next_s.prdata[STAT_BUSY_BIT] = s.out_valid;
                end
                K_DROPS: next_s.prdata = {16'h0000, s.drops};
                K_CLS: next_s.prdata = s.cls[10'((paddr - CLS_BASE) >> 2)];
                K_FLOW: next_s.prdata = s.flow[10'((paddr - FLOW_BASE) >> 2)];
                default: next_s.prdata = REG_RESET;
            endcase
        end
        if (psel && penable && pwrite) begin
            kind = reg_kind(paddr);
            case (kind)
                K_CTRL: begin
                    if (pwdata[CTRL_CLR_ERR_BIT]) begin
                        next_s.prio_err = 1'b0;
                    end
                    if (pwdata[CTRL_START_BIT] && (s.rstate == RS_IDLE || s.rstate == RS_DONE)) begin
                        next_s.rstate = RS_SEND_REQ;
                    end
                end
                K_CLS: begin
                    widx = 10'((paddr - CLS_BASE) >> 2);
                    // a dynamic entry outside its band is refused, not clipped
                    if (pwdata[CLS_DYN_BIT] && pwdata[CLS_VALID_BIT] &&
                        (wprio < DYN_PRIO_MIN || wprio > DYN_PRIO_MAX)) begin
                        next_s.prio_err = 1'b1; // R15
                    end else begin
                        next_s.cls[widx] = pwdata; // R16
                    end
                end
                K_FLOW: next_s.flow[10'((paddr - FLOW_BASE) >> 2)] = pwdata; // R21
                default: begin
                end
            endcase
        end

        if (s.out_valid && link.up_ready) begin
            next_s.out_valid = 1'b0;
        end

        // highest priority wins; strict compare keeps the lowest index on ties
        for (int i = 0; i < NCLS; i++) begin
            fl = s.cls[i][CLS_FLOW_LSB +: FID_W];
            ok = s.cls[i][CLS_VALID_BIT] && req_match[i] && s.flow[fl][FLOW_ACTIVE_BIT]; // R2
            if (req_mgmt) begin
                ok = ok && s.cls[i][CLS_MGMT_BIT] && s.cls[i][CLS_TYPE_LSB +: 8] == req_mgmt_type; // R9
            end else begin
                ok = ok && !s.cls[i][CLS_MGMT_BIT];
            end
            if (ok && (!best_hit || s.cls[i][CLS_PRIO_LSB +: 8] > best_prio)) begin
                best_hit = 1'b1; // R22 R19
                best_prio = s.cls[i][CLS_PRIO_LSB +: 8];
                best_flow = fl;
            end
        end
        for (int j = NFLOW - 1; j >= 0; j--) begin
            if (s.flow[j][FLOW_ACTIVE_BIT] && s.flow[j][FLOW_NAME_LSB +: 8] == req_class_name) begin
                name_hit = 1'b1; // R14
                name_flow = FID_W'(j);
            end
        end
        if (req_mgmt) begin
            chosen = best_hit ? best_flow : FALLBACK_FLOW_ID; // R11
            if (req_ranging) begin
                chosen = FALLBACK_FLOW_ID; // R10
            end
        end else begin
            if (name_hit) begin
                chosen = name_flow; // R14
            end
            if (best_hit && best_prio >= req_priority) begin
                chosen = best_flow; // R14 R13
            end
        end

        if (req_valid && req_ready) begin
            if (s.flow[chosen][FLOW_NOFRAG_BIT] &&
                req_len > s.flow[chosen][FLOW_GRANT_LSB +: 16] && chosen != FALLBACK_FLOW_ID) begin // R7
                if (s.flow[chosen][FLOW_DROP_BIT]) begin
                    next_s.dropped = 1'b1; // R8
                    next_s.drops = s.drops + 16'h0001;
                end else begin
                    chosen = FALLBACK_FLOW_ID; // R8
                end
            end
            if (!next_s.dropped) begin
                next_s.out_valid = 1'b1;
                next_s.out_flow = chosen; // R1
                next_s.out_len = req_len;
                next_s.out_tos = req_tos;
                next_s.out_mgmt = req_mgmt; // R12
            end
        end

        for (int k = 0; k < NFLOW; k++) begin
            if (!s.flow[k][FLOW_ACTIVE_BIT]) begin
                n_inact = n_inact + 4'h1;
            end
        end
        for (int c = 0; c < NCLS; c++) begin
            fl = s.cls[c][CLS_FLOW_LSB +: FID_W];
            if (s.cls[c][CLS_VALID_BIT] && s.flow[fl][FLOW_ACTIVE_BIT]) begin
                n_imm = n_imm + 4'h1;
            end
        end
        case (s.rstate)
            RS_IDLE: begin
            end
            RS_SEND_REQ: begin
                next_s.msg_valid = 1'b1; // R18
                next_s.msg_type = MSG_REG_REQ;
                next_s.msg_info = {n_imm, n_inact}; // R20
                next_s.rstate = RS_WAIT_RSP;
            end
            RS_WAIT_RSP: begin
                if (link.dn_msg_valid && link.dn_msg_type == MSG_REG_RSP) begin
                    next_s.rstate = RS_SEND_ACK; // R18
                end
            end
            RS_SEND_ACK: begin
                next_s.msg_valid = 1'b1; // R18
                next_s.msg_type = MSG_REG_ACK;
                next_s.rstate = RS_DONE;
            end
            RS_DONE: begin
            end
            default: next_s.rstate = RS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // one output slot; a stalled link holds the request off
    assign req_ready = !s.out_valid || link.up_ready; // R17
    assign req_dropped = s.dropped;
    assign prdata = s.prdata;
    assign pready = psel && penable;
    assign pslverr = psel && penable && s.err_resp;
    assign link.up_valid = s.out_valid;
    assign link.up_flow = s.out_flow;
    assign link.up_len = s.out_len;
    assign link.up_tos = s.out_tos;
    assign link.up_mgmt = s.out_mgmt;
    assign link.up_msg_valid = s.msg_valid;
    assign link.up_msg_type = s.msg_type;
    assign link.up_msg_info = s.msg_info;
endmodule

// ===== sim/sfc_link_assertions.sv
`timescale 1ns/10ps
module sfc_link_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic up_valid,
    input wire logic up_ready,
    input wire logic [sfc_pkg::FID_W-1:0] up_flow,
    input wire logic [sfc_pkg::LEN_W-1:0] up_len,
    input wire logic up_mgmt,
    input wire logic up_msg_valid,
    input wire sfc_pkg::sfc_msg_e up_msg_type,
    input wire logic dn_msg_valid,
    input wire sfc_pkg::sfc_msg_e dn_msg_type
);
    import sfc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    rsp_after_req_a: assert property (up_msg_valid && up_msg_type == MSG_REG_REQ |->
        ##2 dn_msg_valid && dn_msg_type == MSG_REG_RSP) else $error("no response after request");
    ack_after_rsp_a: assert property (dn_msg_valid |-> ##2 up_msg_valid && up_msg_type == MSG_REG_ACK)
        else $error("no acknowledge after response");
    rsp_cause_a: assert property (dn_msg_valid |-> $past(up_msg_valid, 2) && $past(up_msg_type, 2) == MSG_REG_REQ)
        else $error("response without request");
    ack_cause_a: assert property (up_msg_valid && up_msg_type == MSG_REG_ACK |-> $past(dn_msg_valid, 2))
        else $error("acknowledge without response");
    msg_pulse_a: assert property (up_msg_valid |=> !up_msg_valid)
        else $error("message pulse too long");
    dn_quiet_a: assert property (!dn_msg_valid |-> dn_msg_type == MSG_NONE)
        else $error("downstream type without valid");
    msg_kind_a: assert property (up_msg_valid |-> up_msg_type inside {MSG_REG_REQ, MSG_REG_ACK})
        else $error("illegal upstream message type");
    desc_hold_a: assert property (up_valid && !up_ready |=> up_valid && $stable(up_flow) && $stable(up_len))
        else $error("descriptor changed while stalled");
    cover property (up_msg_valid && up_msg_type == MSG_REG_ACK);
    cover property (up_valid && up_mgmt);
    cover property (up_valid ##1 up_valid);
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import sfc_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic req_valid = 0, req_ready, req_mgmt = 0, req_ranging = 0, req_dropped;
    logic [LEN_W-1:0] req_len = '0, us_len;
    logic [7:0] req_tos = 8'h12, req_class_name = '0, req_priority = '0, req_mgmt_type = '0;
    logic [7:0] req_match = '0, us_tos, req_info = '0;
    logic tos_police_en = 0, us_valid, us_mgmt, us_dropped, registered;
    logic ds_valid = 0, ds_match = 0, ds_out_valid;
    logic [FID_W-1:0] ds_flow = '0, us_flow, ds_out_flow;
    logic [NFLOW-1:0] ds_flow_active = 8'h2F;
    logic [NFLOW*8-1:0] flow_tos = 64'hA7A6_A5A4_A3A2_A1A0;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    sfc_link_if lnk();
    sfc_modem #(.NCLS(8)) i_sfc_modem (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_valid(req_valid), .req_ready(req_ready), .req_len(req_len), .req_tos(req_tos),
        .req_class_name(req_class_name), .req_priority(req_priority), .req_match(req_match),
        .req_mgmt(req_mgmt), .req_mgmt_type(req_mgmt_type), .req_ranging(req_ranging),
        .req_dropped(req_dropped), .link(lnk));
    // roomy buckets so only oversized packets hit the policer
    sfc_headend #(.REFILL_BYTES(16'h0100), .BUCKET_MAX(16'h0400)) i_sfc_headend (.pclk(pclk),
        .presetn(presetn), .link(lnk), .flow_tos(flow_tos), .tos_police_en(tos_police_en), .us_valid(us_valid),
        .us_flow(us_flow), .us_len(us_len), .us_tos(us_tos), .us_mgmt(us_mgmt), .us_dropped(us_dropped),
        .registered(registered), .ds_valid(ds_valid), .ds_match(ds_match), .ds_flow(ds_flow),
        .ds_flow_active(ds_flow_active), .ds_out_valid(ds_out_valid), .ds_out_flow(ds_out_flow));
    sfc_link_assertions i_sfc_link_assertions (.pclk(pclk), .presetn(presetn), .up_valid(lnk.up_valid),
        .up_ready(lnk.up_ready), .up_flow(lnk.up_flow), .up_len(lnk.up_len), .up_mgmt(lnk.up_mgmt),
        .up_msg_valid(lnk.up_msg_valid), .up_msg_type(lnk.up_msg_type), .dn_msg_valid(lnk.dn_msg_valid),
        .dn_msg_type(lnk.dn_msg_type));
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (lnk.up_msg_valid === 1'b1 && lnk.up_msg_type === MSG_REG_REQ) begin
            req_info <= lnk.up_msg_info;
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        cmp(rd & mask, exp);
    endtask
    // mt of zero marks a data packet; exp 8 = modem discard, 9 = policer discard
    task automatic send(input logic [15:0] ln, input logic [7:0] nm, input logic [7:0] pr, input logic [7:0] m,
                        input logic [7:0] mt, input logic rg, input logic [3:0] exp);
        logic [3:0] res;
        logic [7:0] tos;
        logic [16:0] lm;
        @(posedge pclk);
        req_valid <= 1'b1;
        req_len <= ln;
        req_class_name <= nm;
        req_priority <= pr;
        req_match <= m;
        req_mgmt <= (mt != 8'h00);
        req_mgmt_type <= mt;
        req_ranging <= rg;
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        res = 4'hF;
        tos = 8'h00;
        lm = '0;
        for (int n = 0; n < 6 && res === 4'hF; n++) begin
            @(negedge pclk);
            if (us_valid === 1'b1) begin
                res = {1'b0, us_flow};
                tos = us_tos;
                lm = {us_mgmt, us_len};
            end else if (req_dropped === 1'b1) begin
                res = 4'h8;
            end else if (us_dropped === 1'b1) begin
                res = 4'h9;
            end
        end
        cmp({28'h0, res}, {28'h0, exp});
        if (res[3] === 1'b0) begin
            cmp({24'h0, tos}, {24'h0, (tos_police_en && mt == 8'h00) ? flow_tos[{exp[2:0], 3'b000} +: 8] : 8'h12});
            cmp({15'h0, lm}, {15'h0, mt != 8'h00, ln});
        end
    endtask
    task automatic ds(input logic mt, input logic [2:0] f, input logic [2:0] exp);
        @(posedge pclk);
        ds_valid <= 1'b1;
        ds_match <= mt;
        ds_flow <= f;
        @(posedge pclk);
        ds_valid <= 1'b0;
        @(negedge pclk);
        cmp({28'h0, ds_out_valid, ds_out_flow}, {28'h0, 1'b1, exp});
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wr(FLOW_BASE, 32'h8000_0000);
        wr(FLOW_BASE + 12'h004, 32'h8011_0000);
        wr(FLOW_BASE + 12'h008, 32'hE022_0020);
        wr(FLOW_BASE + 12'h00C, 32'hC033_0020);
        wr(FLOW_BASE + 12'h010, 32'h0044_0000);
        wr(FLOW_BASE + 12'h014, 32'h8055_0000);
        wr(FLOW_BASE + 12'h018, 32'h8066_0000);
        wr(FLOW_BASE + 12'h01C, 32'h8077_0000);
        wr(CLS_BASE, 32'h8000_0580);
        wr(CLS_BASE + 12'h004, 32'h8000_0190);
        wr(CLS_BASE + 12'h008, 32'h8000_04F0);
        wr(CLS_BASE + 12'h00C, 32'hA005_0310);
        wr(CLS_BASE + 12'h010, 32'hC000_013F);
        wr(CLS_BASE + 12'h014, 32'hC000_0140);
        wr(CLS_BASE + 12'h018, 32'hC000_01C0);
        wr(CLS_BASE + 12'h01C, 32'hC000_05BF);
        rdc(ADDR_STATUS, 32'h0000_0010, 32'h0000_0010);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        cmp({31'h0, er}, 32'h0000_0001);
        cmp(rd, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0003);
        for (int n = 0; n < 20 && registered !== 1'b1; n++) @(negedge pclk);
        cmp({31'h0, registered}, 32'h0000_0001);
        cmp({24'h0, req_info}, 32'h0000_0051);
        rdc(ADDR_STATUS, 32'h0000_003F, 32'h0000_0004);
        repeat (4 * REFILL_CYC) @(posedge pclk);
        send(16'h0010, 8'h11, 8'h00, 8'h00, 8'h00, 1'b0, 4'h1);
        send(16'h0010, 8'h99, 8'h00, 8'h00, 8'h00, 1'b0, 4'h0);
        send(16'h0010, 8'h44, 8'h00, 8'h00, 8'h00, 1'b0, 4'h0);
        send(16'h0010, 8'h11, 8'h80, 8'h01, 8'h00, 1'b0, 4'h5);
        send(16'h0010, 8'h11, 8'h81, 8'h01, 8'h00, 1'b0, 4'h1);
        send(16'h0010, 8'h99, 8'h00, 8'h03, 8'h00, 1'b0, 4'h1);
        send(16'h0010, 8'h99, 8'h00, 8'h04, 8'h00, 1'b0, 4'h0);
        send(16'h0010, 8'h99, 8'h00, 8'h10, 8'h00, 1'b0, 4'h0);
        send(16'h0010, 8'h99, 8'h40, 8'h20, 8'h00, 1'b0, 4'h1);
        send(16'h0010, 8'h99, 8'h00, 8'h40, 8'h00, 1'b0, 4'h0);
        send(16'h0010, 8'h99, 8'h00, 8'h80, 8'h00, 1'b0, 4'h5);
        send(16'h0021, 8'h22, 8'h00, 8'h00, 8'h00, 1'b0, 4'h8);
        send(16'h0020, 8'h22, 8'h00, 8'h00, 8'h00, 1'b0, 4'h2);
        send(16'h0021, 8'h33, 8'h00, 8'h00, 8'h00, 1'b0, 4'h0);
        @(posedge pclk);
        tos_police_en <= 1'b1;
        send(16'h0010, 8'h55, 8'h00, 8'h00, 8'h00, 1'b0, 4'h5);
        send(16'h0010, 8'h00, 8'h00, 8'h08, 8'h05, 1'b0, 4'h3);
        send(16'h0010, 8'h00, 8'h00, 8'h08, 8'h06, 1'b0, 4'h0);
        send(16'h0010, 8'h00, 8'h00, 8'h08, 8'h05, 1'b1, 4'h0);
        send(16'h0010, 8'h99, 8'h00, 8'h08, 8'h00, 1'b0, 4'h0);
        send(16'h0800, 8'h00, 8'h00, 8'h00, 8'h06, 1'b0, 4'h0);
        send(16'h0800, 8'h00, 8'h00, 8'h00, 8'h06, 1'b0, 4'h0);
        send(16'h0800, 8'h11, 8'h00, 8'h00, 8'h00, 1'b0, 4'h9);
        rdc(ADDR_DROPS, 32'h0000_FFFF, 32'h0000_0001);
        ds(1'b1, 3'h5, 3'h5);
        ds(1'b1, 3'h4, 3'h0);
        ds(1'b0, 3'h2, 3'h0);
        tally_and_finish();
    end
endmodule
